// ===== verilog/qrb_quad_read.sv
`timescale 1ns/1ps
module qrb_quad_read (
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire qrb_pkg::qrb_link_t link_in,
    output logic      [3:0]         dq_out,
    output logic      [3:0]         dq_oe
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [4:0] dummy_clks(input logic [1:0] dc);
        unique case (dc)
            2'b00: dummy_clks = qrb_pkg::DUMMY_DC00;
            2'b01: dummy_clks = qrb_pkg::DUMMY_DC01;
            2'b10: dummy_clks = qrb_pkg::DUMMY_DC10;
            2'b11: dummy_clks = qrb_pkg::DUMMY_DC11;
        endcase
    endfunction

    // Wrap keeps upper bits; 8..64 byte units never cross a page
    function automatic logic [31:0] step_addr(input logic [31:0] a,
                                              input logic en,
                                              input logic [1:0] depth);
        logic [31:0] mask;
        logic [31:0] inc;
        mask = 32'h0;
        inc  = a + 32'h1;
        if (en) begin
            mask      = {24'h0, (qrb_pkg::WRAP_UNIT_MIN << depth) - 8'h1};
            step_addr = (a & ~mask) | (inc & mask);
        end else begin
            step_addr = inc;
        end
    endfunction

    // ------------------------------------------------------------------
    // Link capture
    // ------------------------------------------------------------------
    qrb_pkg::qrb_link_t lk;
    logic               s_rise;
    logic               s_fall;
    logic               c_fall;
    logic               c_rise;

    qrb_link_sync u_sync (
        .clk       (clk),
        .rstn      (rstn),
        .pins      (link_in),
        .synced    (lk),
        .sclk_rise (s_rise),
        .sclk_fall (s_fall),
        .cs_fall   (c_fall),
        .cs_rise   (c_rise)
    );

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [4:0]  ctrl_ff;
    logic [7:0]  cfg_ff;
    logic [31:0] boot_ff;
    logic [7:0]  mem_ptr_ff;
    logic [7:0]  mem [qrb_pkg::MEM_BYTES];
    logic [31:0] status;
    logic        wr_en;
    logic        rd_en;
    logic        fallback;

    assign wr_en    = psel & penable & pwrite;
    assign rd_en    = psel & penable & ~pwrite;
    assign pready   = 1'b1;
    assign fallback = wr_en && paddr == qrb_pkg::OFS_CTRL && pwdata[qrb_pkg::CTRL_FALLBK];

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_ff <= 5'h0;
            cfg_ff  <= 8'h0;
            boot_ff <= qrb_pkg::BOOT_RST;
        end else if (wr_en) begin
            if (paddr == qrb_pkg::OFS_CTRL) begin
                ctrl_ff <= {1'b0, pwdata[3:0]};
                if (pwdata[qrb_pkg::CTRL_FALLBK])
                    ctrl_ff[qrb_pkg::CTRL_FOUR] <= 1'b0;
            end
            if (paddr == qrb_pkg::OFS_CFG)
                cfg_ff <= pwdata[7:0];
            if (paddr == qrb_pkg::OFS_BOOT)
                boot_ff <= pwdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mem_ptr_ff <= 8'h0;
        end else if ((wr_en || rd_en) && paddr == qrb_pkg::OFS_MEM_DATA) begin
            mem_ptr_ff <= mem_ptr_ff + 8'h1;
        end else if (wr_en && paddr == qrb_pkg::OFS_MEM_PTR) begin
            mem_ptr_ff <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (wr_en && paddr == qrb_pkg::OFS_MEM_DATA)
            mem[mem_ptr_ff] <= pwdata[7:0];
    end

    logic       qe;
    logic       four;
    logic       wide;
    logic       busy;
    logic [1:0] dc;
    assign qe   = ctrl_ff[qrb_pkg::CTRL_QE];
    assign four = ctrl_ff[qrb_pkg::CTRL_FOUR];
    assign wide = ctrl_ff[qrb_pkg::CTRL_WIDE];
    assign busy = ctrl_ff[qrb_pkg::CTRL_BUSY];
    assign dc   = {cfg_ff[qrb_pkg::CFG_DC_HI], cfg_ff[qrb_pkg::CFG_DC_LO]};

    // ------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------
    qrb_pkg::qrb_state_t state_ff;
    logic [31:0] sh_ff;
    logic [31:0] addr_ff;
    logic [4:0]  cnt_ff;
    logic [4:0]  lim_ff;
    logic        cont_ff;
    logic        wrap_en_ff;
    logic [1:0]  wrap_dep_ff;
    logic        boot_pend_ff;
    logic        rst_arm_ff;
    logic        single_ff;
    logic        wrap_rd_ff;
    logic        half_ff;
    logic [2:0]  bit_ff;
    logic [3:0]  dq_o_ff;
    logic [3:0]  dq_oe_ff;

    logic [31:0] nxt_sh;
    logic [7:0]  rd_byte;
    logic [7:0]  in_byte;
    logic        soft_rst;
    logic [4:0]  boot_dly;

    assign nxt_sh   = (four || state_ff != qrb_pkg::ST_CMD && state_ff != qrb_pkg::ST_WRAP)
                    ? {sh_ff[27:0], lk.dq} : {sh_ff[30:0], lk.dq[0]};
    assign in_byte  = nxt_sh[7:0];
    assign rd_byte  = mem[addr_ff[7:0]];
    assign boot_dly = qrb_pkg::BOOT_DLY_MIN
                    + {2'b00, boot_ff[qrb_pkg::BOOT_DLY_LO +: 2], 1'b0};
    assign soft_rst = s_rise && state_ff == qrb_pkg::ST_CMD && rst_arm_ff
                    && cnt_ff == (four ? 5'h1 : 5'h7) && in_byte == qrb_pkg::CMD_RST_GO;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_ff <= qrb_pkg::ST_IDLE;
            sh_ff    <= 32'h0;
            addr_ff  <= 32'h0;
            cnt_ff   <= 5'h0;
            lim_ff   <= 5'h0;
            cont_ff  <= 1'b0;
            single_ff <= 1'b0;
            wrap_rd_ff <= 1'b0;
        end else if (c_rise || lk.cs_n) begin
            state_ff <= qrb_pkg::ST_IDLE;
            if (fallback)
                cont_ff <= 1'b0;
        end else if (c_fall) begin
            cnt_ff <= 5'h0;
            if (boot_pend_ff && !boot_ff[qrb_pkg::BOOT_OFF]) begin
                state_ff  <= qrb_pkg::ST_DUMMY;
                lim_ff    <= boot_dly;
                addr_ff   <= {boot_ff[31:qrb_pkg::BOOT_SA_LO], 4'h0};
                single_ff <= ~qe;
                wrap_rd_ff <= 1'b0;
            end else if (cont_ff) begin
                state_ff  <= qrb_pkg::ST_ADDR;
                single_ff <= 1'b0;
                // Dummy count still sits in lim_ff; reload address length
                lim_ff    <= (wide || !wrap_rd_ff)
                           ? qrb_pkg::NIB_ADDR4 : qrb_pkg::NIB_ADDR3;
            end else begin
                state_ff <= qrb_pkg::ST_CMD;
            end
        end else if (s_rise) begin
            sh_ff  <= nxt_sh;
            cnt_ff <= cnt_ff + 5'h1;
            unique case (state_ff)
                qrb_pkg::ST_CMD: begin
                    if (cnt_ff == (four ? 5'h1 : 5'h7)) begin
                        cnt_ff <= 5'h0;
                        if (in_byte == qrb_pkg::CMD_QUAD_RD || in_byte == qrb_pkg::CMD_QUAD_RD_A
                            || in_byte == qrb_pkg::CMD_WIDE_QUAD_RD) begin
                            state_ff   <= busy ? qrb_pkg::ST_IGN : qrb_pkg::ST_ADDR;
                            lim_ff     <= (wide || in_byte == qrb_pkg::CMD_WIDE_QUAD_RD)
                                        ? qrb_pkg::NIB_ADDR4 : qrb_pkg::NIB_ADDR3;
                            wrap_rd_ff <= in_byte != qrb_pkg::CMD_WIDE_QUAD_RD;
                            single_ff  <= 1'b0;
                        end else if (in_byte == qrb_pkg::CMD_BURST_CFG) begin
                            state_ff <= qrb_pkg::ST_WRAP;
                        end else begin
                            state_ff <= qrb_pkg::ST_IGN;
                        end
                    end
                end
                qrb_pkg::ST_ADDR: begin
                    if (cnt_ff == lim_ff - 5'h1) begin
                        addr_ff  <= lim_ff == qrb_pkg::NIB_ADDR4 ? nxt_sh
                                  : {8'h00, nxt_sh[23:0]};
                        state_ff <= qrb_pkg::ST_MODE;
                        cnt_ff   <= 5'h0;
                    end
                end
                qrb_pkg::ST_MODE: begin
                    if (cnt_ff == qrb_pkg::MODE_CLKS - 5'h1) begin
                        cont_ff  <= in_byte[7:4] == ~in_byte[3:0];
                        state_ff <= qrb_pkg::ST_DUMMY;
                        lim_ff   <= dummy_clks(dc) - qrb_pkg::MODE_CLKS;
                        cnt_ff   <= 5'h0;
                    end
                end
                qrb_pkg::ST_DUMMY: begin
                    if (cnt_ff >= lim_ff - 5'h1)
                        state_ff <= qrb_pkg::ST_DATA;
                end
                qrb_pkg::ST_WRAP: begin
                    if (cnt_ff == (four ? 5'h1 : 5'h7))
                        state_ff <= qrb_pkg::ST_IGN;
                end
                default: begin
                end
            endcase
        end else if (s_fall && state_ff == qrb_pkg::ST_DATA) begin
            if ((single_ff && bit_ff == 3'h0) || (!single_ff && half_ff))
                addr_ff <= step_addr(addr_ff, wrap_en_ff & wrap_rd_ff, wrap_dep_ff);
        end
    end

    // ------------------------------------------------------------------
    // Wrap, boot and reset-command bookkeeping
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn || soft_rst) begin
            wrap_en_ff  <= 1'b0;
            wrap_dep_ff <= 2'b00;
        end else if (s_rise && state_ff == qrb_pkg::ST_WRAP
                     && cnt_ff == (four ? 5'h1 : 5'h7)) begin
            wrap_en_ff  <= ~in_byte[4];
            wrap_dep_ff <= in_byte[1:0];
        end
    end

    // Pending survives until a frame starts, so a late enable still boots
    always_ff @(posedge clk) begin
        if (!rstn || soft_rst) begin
            boot_pend_ff <= 1'b1;
        end else if (c_fall) begin
            boot_pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rst_arm_ff <= 1'b0;
        end else if (s_rise && state_ff == qrb_pkg::ST_CMD
                     && cnt_ff == (four ? 5'h1 : 5'h7)) begin
            rst_arm_ff <= in_byte == qrb_pkg::CMD_RST_ARM;
        end
    end

    // ------------------------------------------------------------------
    // Output drive on falling clock
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn || lk.cs_n || state_ff != qrb_pkg::ST_DATA) begin
            dq_o_ff  <= 4'h0;
            dq_oe_ff <= 4'h0;
            half_ff  <= 1'b0;
            bit_ff   <= 3'h7;
        end else if (s_fall) begin
            if (single_ff) begin
                dq_o_ff  <= {2'b00, rd_byte[bit_ff], 1'b0};
                dq_oe_ff <= 4'h2;
                bit_ff   <= bit_ff - 3'h1;
            end else begin
                dq_o_ff  <= half_ff ? rd_byte[3:0] : rd_byte[7:4];
                dq_oe_ff <= 4'hF;
                half_ff  <= ~half_ff;
            end
        end
    end

    assign dq_out = dq_o_ff;
    assign dq_oe  = dq_oe_ff;

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    assign status = {16'h0, state_ff, 3'h0, boot_pend_ff, wrap_dep_ff, wrap_en_ff, cont_ff};

    always_comb begin
        prdata  = 32'h0;
        pslverr = 1'b0;
        if (rd_en) begin
            unique case (paddr)
                qrb_pkg::OFS_CTRL:     prdata = {28'h0, ctrl_ff[3:0]};
                qrb_pkg::OFS_CFG:      prdata = {24'h0, cfg_ff};
                qrb_pkg::OFS_BOOT:     prdata = boot_ff;
                qrb_pkg::OFS_STATUS:   prdata = status;
                qrb_pkg::OFS_MEM_PTR:  prdata = {24'h0, mem_ptr_ff};
                qrb_pkg::OFS_MEM_DATA: prdata = {24'h0, mem[mem_ptr_ff]};
                default:               pslverr = 1'b1;
            endcase
        end else if (psel && penable) begin
            pslverr = !(paddr == qrb_pkg::OFS_CTRL || paddr == qrb_pkg::OFS_CFG
                      || paddr == qrb_pkg::OFS_BOOT || paddr == qrb_pkg::OFS_MEM_PTR
                      || paddr == qrb_pkg::OFS_MEM_DATA);
        end
    end
endmodule

// ===== verilog/qrb_pkg.sv
package qrb_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_CFG      = 8'h04;
    localparam logic [7:0]  OFS_BOOT     = 8'h08;
    localparam logic [7:0]  OFS_STATUS   = 8'h0C;
    localparam logic [7:0]  OFS_MEM_PTR  = 8'h10;
    localparam logic [7:0]  OFS_MEM_DATA = 8'h14;

    // CTRL fields
    localparam int          CTRL_QE      = 0;
    localparam int          CTRL_FOUR    = 1;
    localparam int          CTRL_WIDE    = 2;
    localparam int          CTRL_BUSY    = 3;
    localparam int          CTRL_FALLBK  = 4;
    // CFG dummy select bits
    localparam int          CFG_DC_LO    = 6;
    localparam int          CFG_DC_HI    = 7;
    // BOOT fields
    localparam int          BOOT_OFF     = 0;
    localparam int          BOOT_DLY_LO  = 1;
    localparam int          BOOT_SA_LO   = 4;
    localparam logic [31:0] BOOT_RST     = 32'hFFFF_FFFF;

    // ------------------------------------------------------------------
    // Commands
    // ------------------------------------------------------------------
    localparam logic [7:0]  CMD_QUAD_RD_A   = 8'hEA;
    localparam logic [7:0]  CMD_QUAD_RD     = 8'hEB;
    localparam logic [7:0]  CMD_WIDE_QUAD_RD = 8'hEC;
    localparam logic [7:0]  CMD_BURST_CFG   = 8'hC0;
    localparam logic [7:0]  CMD_RST_ARM     = 8'h66;
    localparam logic [7:0]  CMD_RST_GO      = 8'h99;

    // ------------------------------------------------------------------
    // Counts
    // ------------------------------------------------------------------
    localparam logic [4:0]  NIB_ADDR3    = 5'h06;
    localparam logic [4:0]  NIB_ADDR4    = 5'h08;
    localparam logic [4:0]  MODE_CLKS    = 5'h02;
    localparam logic [4:0]  DUMMY_DC00   = 5'h06;
    localparam logic [4:0]  DUMMY_DC01   = 5'h04;
    localparam logic [4:0]  DUMMY_DC10   = 5'h08;
    localparam logic [4:0]  DUMMY_DC11   = 5'h0A;
    localparam logic [4:0]  BOOT_DLY_MIN = 5'h07;
    localparam logic [7:0]  WRAP_UNIT_MIN = 8'h08;
    localparam int          MEM_BYTES    = 256;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       cs_n;
        logic       sclk;
        logic [3:0] dq;
    } qrb_link_t;

    typedef enum logic [7:0] {
        ST_IDLE  = 8'b0000_0001,
        ST_CMD   = 8'b0000_0010,
        ST_ADDR  = 8'b0000_0100,
        ST_MODE  = 8'b0000_1000,
        ST_DUMMY = 8'b0001_0000,
        ST_DATA  = 8'b0010_0000,
        ST_WRAP  = 8'b0100_0000,
        ST_IGN   = 8'b1000_0000
    } qrb_state_t;

endpackage

// ===== verilog/qrb_link_sync.sv
`timescale 1ns/1ps
module qrb_link_sync (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire qrb_pkg::qrb_link_t pins,
    output qrb_pkg::qrb_link_t     synced,
    output logic                   sclk_rise,
    output logic                   sclk_fall,
    output logic                   cs_fall,
    output logic                   cs_rise
);
    // ------------------------------------------------------------------
    // Two-stage capture; stages two and three feed edge detect
    // ------------------------------------------------------------------
    qrb_pkg::qrb_link_t meta_ff;
    qrb_pkg::qrb_link_t sync_ff;
    qrb_pkg::qrb_link_t last_ff;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta_ff <= '{cs_n: 1'b1, sclk: 1'b0, dq: 4'h0};
            sync_ff <= '{cs_n: 1'b1, sclk: 1'b0, dq: 4'h0};
            last_ff <= '{cs_n: 1'b1, sclk: 1'b0, dq: 4'h0};
        end else begin
            meta_ff <= pins;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign synced    = sync_ff;
    assign sclk_rise = sync_ff.sclk & ~last_ff.sclk & ~sync_ff.cs_n;
    assign sclk_fall = ~sync_ff.sclk & last_ff.sclk & ~sync_ff.cs_n;
    assign cs_fall   = ~sync_ff.cs_n & last_ff.cs_n;
    assign cs_rise   = sync_ff.cs_n & ~last_ff.cs_n;
endmodule

// ===== verification/qrb_quad_read_chk.sv
`timescale 1ns/1ps
module qrb_quad_read_chk (
    input wire logic               clk,
    input wire logic               rstn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire qrb_pkg::qrb_link_t link_in,
    input wire logic [3:0]         dq_out,
    input wire logic [3:0]         dq_oe
);
    // ------------------
    // Port checks
    // ------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire acc = psel && penable;
    AST_OE_SHAPE:
        assert property (dq_oe inside {4'h0, 4'h2, 4'hF}) else $error("bad enable");
    AST_OUT_HOLD:
        assert property ((!link_in.cs_n && link_in.sclk) [*4] |-> $stable(dq_out))
        else $error("data moved with clock high");
    AST_DATA_ON_FALL:
        assert property ($changed(dq_out) |-> !$past(link_in.sclk, 2)) else $error("data off fall");
    AST_OE_NEEDS_CS:
        assert property (dq_oe != 4'h0 |-> !$past(link_in.cs_n, 5)) else $error("drive unselected");
    AST_OE_DROP:
        assert property ($rose(link_in.cs_n) |-> ##[1:6] dq_oe == 4'h0) else $error("no release");
    AST_RST_QUIET:
        assert property (disable iff (1'b0) !rstn |=> dq_oe == 4'h0) else $error("drive in reset");
    AST_PREADY:
        assert property (acc |-> pready) else $error("no ready");
    AST_BUS_IDLE:
        assert property (!acc |-> prdata == 32'h0 && !pslverr) else $error("bus not idle");
    AST_UNMAPPED:
        assert property (acc && paddr > qrb_pkg::OFS_MEM_DATA |-> pslverr) else $error("no error");
    COV_QUAD: cover property (dq_oe == 4'hF);
    COV_SINGLE: cover property (dq_oe == 4'h2);
    COV_ERR: cover property (acc && pslverr);
endmodule

bind qrb_quad_read qrb_quad_read_chk u_chk (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_in(link_in),
    .dq_out(dq_out), .dq_oe(dq_oe)
);

// ===== verification/qrb_host_model.sv
`timescale 1ns/1ps
module qrb_host_model (
    input  wire logic         clk,
    input  wire logic [3:0]   dq_out,
    input  wire logic [3:0]   dq_oe,
    output qrb_pkg::qrb_link_t link
);
    // ------------------
    // Host side of link
    // ------------------
    logic       cs_n_ff = 1'b1;
    logic       sclk_ff = 1'b0;
    logic [3:0] hdq_ff  = 4'h0;
    logic       oe_seen = 1'b0;
    logic       cs_q    = 1'b1;
    assign link = '{cs_n_ff, sclk_ff, (dq_oe & dq_out) | (~dq_oe & hdq_ff)};
    // Cleared on the edge after select falls, so each frame starts clean
    always @(posedge clk) begin
        cs_q <= cs_n_ff;
        if (dq_oe != 4'h0)
            oe_seen <= 1'b1;
        else if (cs_q && !cs_n_ff)
            oe_seen <= 1'b0;
    end
    // Released lines toggle so a stale level never passes for device data
    task automatic tick(input logic [3:0] d, input logic drv, output logic [3:0] q);
        @(posedge clk);
        sclk_ff <= 1'b0;
        hdq_ff  <= drv ? d : ~hdq_ff;
        repeat (4) @(posedge clk);
        sclk_ff <= 1'b1;
        repeat (2) @(posedge clk);
        q = link.dq;
        @(posedge clk);
    endtask
    task automatic put(input logic [7:0] b, input logic quad);
        logic [3:0] q;
        for (int i = quad ? 1 : 7; i >= 0; i--)
            tick(quad ? b[i*4 +: 4] : {4{b[i]}}, 1'b1, q);
    endtask
    task automatic get(input logic quad, output logic [7:0] b);
        logic [3:0] q;
        for (int i = quad ? 1 : 7; i >= 0; i--) begin
            tick(4'h0, 1'b0, q);
            if (quad) b[i*4 +: 4] = q;
            else b[i] = q[1];
        end
    endtask
    task automatic idle(input int n);
        logic [3:0] q;
        repeat (n) tick(4'h0, 1'b0, q);
    endtask
    task automatic open_frame();
        @(posedge clk);
        cs_n_ff <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic close_frame();
        @(posedge clk);
        sclk_ff <= 1'b0;
        repeat (4) @(posedge clk);
        cs_n_ff <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
endmodule

// ===== verification/quad_io_read_burst_fastboot_tb.sv
`timescale 1ns/1ps
module quad_io_read_burst_fastboot_tb;
    // ------------------
    // Bench
    // ------------------
    logic               clk = 1'b0;
    logic               rstn = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    qrb_pkg::qrb_link_t link;
    logic [3:0]         dq_out;
    logic [3:0]         dq_oe;
    logic [7:0]         mem [256];
    logic [31:0]        rv;
    logic               er;
    logic               wrap_on = 1'b0;
    logic [31:0]        wmask = 32'h0;
    int                 n_errors = 0;
    int                 comparisons = 0;
    always #12.5 clk = ~clk;
    qrb_quad_read dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_in(link), .dq_out(dq_out), .dq_oe(dq_oe));
    qrb_host_model host (.clk(clk), .dq_out(dq_out), .dq_oe(dq_oe), .link(link));
    task automatic chk32(input logic [31:0] g, input logic [31:0] x);
        comparisons++;
        if (g !== x) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] x);
        chk32({24'h0, g}, {24'h0, x});
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic sendf(input logic [7:0] c, input logic [7:0] d, input int nb, input logic f);
        host.open_frame();
        host.put(c, f);
        if (nb > 0) host.put(d, f);
        host.close_frame();
    endtask
    // Model of one read frame; a zero command means no instruction is sent
    task automatic rd(input logic [7:0] c, input logic [31:0] a, input logic [7:0] m,
                      input int na, input int dm, input int n, input logic f, input logic qd);
        logic [7:0] b;
        host.open_frame();
        if (c != 8'h00) host.put(c, f);
        for (int i = na / 2 - 1; i >= 0; i--) host.put(a[i*8 +: 8], 1'b1);
        if (na > 0) host.put(m, 1'b1);
        host.idle(na > 0 ? dm - 2 : dm);
        repeat (n) begin
            host.get(qd, b);
            chk8(b, mem[a[7:0]]);
            if (wrap_on && c != qrb_pkg::CMD_WIDE_QUAD_RD) a = (a & ~wmask) | ((a + 1) & wmask);
            else a = a + 1;
        end
        host.close_frame();
    endtask
    task automatic complete_run();
        if (n_errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        logic [7:0]  ra [5];
        logic [31:0] rx [5];
        logic [7:0]  cm [3];
        int          dt [4];
        logic [31:0] r;
        void'($urandom(32'hCC41_7E4B));
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        ra = '{qrb_pkg::OFS_CTRL, qrb_pkg::OFS_CFG, qrb_pkg::OFS_BOOT, qrb_pkg::OFS_STATUS, 8'h18};
        rx = '{32'h0, 32'h0, qrb_pkg::BOOT_RST, 32'h0000_0110, 32'h0};
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ra[i], 32'h0);
            chk32(rv, rx[i]);
            chk8({7'h0, er}, {7'h0, i == 4});
        end
        apb(1'b1, qrb_pkg::OFS_MEM_PTR, 32'h0);
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'($urandom);
            apb(1'b1, qrb_pkg::OFS_MEM_DATA, {24'h0, mem[i]});
        end
        apb(1'b1, qrb_pkg::OFS_CTRL, 32'h1);
        dt = '{6, 4, 8, 10};
        for (int d = 0; d < 4; d++) begin
            apb(1'b1, qrb_pkg::OFS_CFG, 32'(d) << 6);
            rd(qrb_pkg::CMD_QUAD_RD, $urandom, 8'h00, 6, dt[d], 3, 1'b0, 1'b1);
        end
        apb(1'b1, qrb_pkg::OFS_CFG, 32'h0);
        rd(qrb_pkg::CMD_WIDE_QUAD_RD, 32'hFFFF_FFFE, 8'h00, 8, 6, 3, 1'b0, 1'b1);
        apb(1'b1, qrb_pkg::OFS_CTRL, 32'h3);
        for (int d = 0; d < 4; d++) begin
            sendf(qrb_pkg::CMD_BURST_CFG, 8'(d), 1, 1'b1);
            wrap_on = 1'b1;
            wmask = (32'h8 << d) - 32'h1;
            rd(qrb_pkg::CMD_QUAD_RD_A, $urandom, 8'h00, 6, 6, (8 << d) + 3, 1'b1, 1'b1);
        end
        sendf(qrb_pkg::CMD_BURST_CFG, 8'h10, 1, 1'b1);
        wrap_on = 1'b0;
        rd(qrb_pkg::CMD_QUAD_RD, 32'h0000_00FC, 8'h00, 6, 6, 6, 1'b1, 1'b1);
        rd(qrb_pkg::CMD_QUAD_RD, $urandom, 8'hA5, 6, 6, 2, 1'b1, 1'b1);
        apb(1'b1, qrb_pkg::OFS_CTRL, 32'h11);
        rd(qrb_pkg::CMD_QUAD_RD, $urandom, 8'h00, 6, 6, 2, 1'b0, 1'b1);
        rd(qrb_pkg::CMD_QUAD_RD, $urandom, 8'hA5, 6, 6, 2, 1'b0, 1'b1);
        cm = '{8'h5A, 8'hF0, 8'h0F};
        foreach (cm[i]) rd(8'h00, $urandom, cm[i], 6, 6, 2, 1'b0, 1'b1);
        rd(8'h00, $urandom, 8'h55, 6, 6, 2, 1'b0, 1'b1);
        rd(qrb_pkg::CMD_QUAD_RD, $urandom, 8'hA5, 6, 6, 2, 1'b0, 1'b1);
        sendf(8'hFF, 8'h00, 0, 1'b0);
        rd(qrb_pkg::CMD_QUAD_RD, $urandom, 8'h00, 6, 6, 2, 1'b0, 1'b1);
        apb(1'b1, qrb_pkg::OFS_CTRL, 32'h9);
        host.open_frame();
        host.put(qrb_pkg::CMD_QUAD_RD, 1'b0);
        host.idle(20);
        host.close_frame();
        chk8({7'h0, host.oe_seen}, 8'h00);
        apb(1'b0, qrb_pkg::OFS_CTRL, 32'h0);
        chk32(rv, 32'h9);
        for (int q = 0; q < 2; q++) begin
            r = $urandom & 32'hFFFF_FFF0;
            apb(1'b1, qrb_pkg::OFS_CTRL, 32'(q));
            apb(1'b1, qrb_pkg::OFS_BOOT, r | 32'h6);
            sendf(qrb_pkg::CMD_RST_ARM, 8'h00, 0, 1'b0);
            sendf(qrb_pkg::CMD_RST_GO, 8'h00, 0, 1'b0);
            rd(8'h00, r, 8'h00, 0, 13, 2, 1'b0, q[0]);
        end
        rd(qrb_pkg::CMD_QUAD_RD, $urandom, 8'h00, 6, 6, 2, 1'b0, 1'b1);
        complete_run();
    end
    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        complete_run();
    end
endmodule
